/* lcd_frame_defines.svh */
`ifndef LCD_FRAME_DEFINES_SVH
`define LCD_FRAME_DEFINES_SVH
// ********************************************************
// register byte addresses
// ********************************************************
`define REG_CTRL_A      8'h00
`define REG_CTRL_B      8'h04
`define REG_FRAME_RATE  8'h08
`define REG_CONTRAST    8'h0C
`define REG_STATUS      8'h10
`define REG_MEM_BASE    8'h20
`define REG_MEM_LAST    8'h2C
// ********************************************************
// control a field positions
// ********************************************************
`define CA_ENABLE       7
`define CA_LOWPWR       6
`define CA_FLAG         4
`define CA_IE           3
`define CA_BLANK        0
// ********************************************************
// control b field positions
// ********************************************************
`define CB_CLKSEL       7
`define CB_BIAS_HALF    6
`define CB_MUX_HI       5
`define CB_MUX_LO       4
`define CB_EXTCLK       8
`define CB_PWRRED       9
// ********************************************************
// reset values and counts
// ********************************************************
`define RST_ZERO        32'h0000_0000
`define PRESCALE_BITS   12
`define DRIVE_UNIT_CYC  16
`endif

/* lcd_frame_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port checks for the frame controller
// ****************************************
module lcd_frame_monitor #(
  parameter int SEG_COUNT = 40
) (
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready,
  input wire logic [1:0]           s_axi_rresp,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic                 supply_ready,
  input wire logic [SEG_COUNT-1:0] seg_oe,
  input wire logic [SEG_COUNT-1:0] seg_lcd_owned,
  input wire logic [3:0]           com_oe,
  input wire logic [3:0]           com_lcd_owned
);
  // one domain
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // answers stand until taken
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped early");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped early");
  // refused reads return zero data
  property p_rerr; s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0000_0000; endproperty
  a_rerr: assert property (p_rerr) else $error("error read carries data");
  property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_blat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_blat: assert property (p_blat) else $error("write answer late");
  // a pending answer blocks the next write address
  property p_bblock; s_axi_bvalid |-> !s_axi_awready; endproperty
  a_bblock: assert property (p_bblock) else $error("write taken while answer pending");
  // a pin is driven only while the lcd owns it
  property p_segown; (seg_oe & ~seg_lcd_owned) == '0; endproperty
  a_segown: assert property (p_segown) else $error("port segment pin driven");
  property p_comown; (com_oe & ~com_lcd_owned) == 4'h0; endproperty
  a_comown: assert property (p_comown) else $error("port common pin driven");
  // one cycle of slack for the registered pins
  property p_inhibit; !supply_ready [*2] |-> seg_oe == '0 && com_oe == 4'h0; endproperty
  a_inhibit: assert property (p_inhibit) else $error("pins driven before supply");
endmodule // lcd_frame_monitor

bind segment_lcd_frame_controller lcd_frame_monitor #(.SEG_COUNT(SEG_COUNT)) u_mon (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rresp, .s_axi_rdata, .supply_ready, .seg_oe, .seg_lcd_owned,
  .com_oe, .com_lcd_owned);
`default_nettype wire

/* lcd_frame_pkg.sv */
package lcd_frame_pkg;
  // ********************************************************
  // frame sequencer states
  // ********************************************************
  typedef enum logic [1:0] {
    ST_OFF,
    ST_RUN,
    ST_BLANK
  } seq_state_e;
endpackage

/* lcd_panel_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// passive panel: segments 0 and 1 on common 0
// ****************************************
module lcd_panel_model (
  input  wire logic       aclk,
  input  wire logic [1:0] seg_level,
  input  wire logic [1:0] seg_oe,
  input  wire logic       com_level,
  input  wire logic       com_oe,
  output logic [15:0]     on0,
  output logic [15:0]     on1,
  output logic [15:0]     pos0,
  output logic [15:0]     neg0
);
  // the glass has no reset pin, counts start empty
  initial
  begin
    on0 = 16'h0000;
    on1 = 16'h0000;
    pos0 = 16'h0000;
    neg0 = 16'h0000;
  end
  // a cell sees voltage only while both electrodes are driven apart
  always @(posedge aclk)
  begin
    if (com_oe === 1'b1 && seg_oe[0] === 1'b1 && seg_level[0] !== com_level)
    begin
      on0 <= on0 + 16'h0001;
      // sign of the voltage, to see it alternate
      if (seg_level[0] === 1'b1)
        pos0 <= pos0 + 16'h0001;
      else
        neg0 <= neg0 + 16'h0001;
    end
    if (com_oe === 1'b1 && seg_oe[1] === 1'b1 && seg_level[1] !== com_level)
      on1 <= on1 + 16'h0001;
  end
endmodule // lcd_panel_model
`default_nettype wire

/* segment_lcd_frame_controller.sv */
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_frame_defines.svh"

module segment_lcd_frame_controller #(
  parameter int SEG_COUNT = 40
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic               timer_oscillator_pin,
  input  wire logic               supply_ready,
  input  wire logic               sleep_idle_or_save,
  input  wire logic               sleep_adc_noise,
  input  wire logic               frame_irq_ack,
  output logic                    ext_clock_buffer_en,
  output logic                    frame_irq,
  output logic [SEG_COUNT-1:0]    seg_level,
  output logic [SEG_COUNT-1:0]    seg_oe,
  output logic [SEG_COUNT-1:0]    seg_lcd_owned,
  output logic [3:0]              com_level,
  output logic [3:0]              com_oe,
  output logic [3:0]              com_lcd_owned,
  output logic                    mid_buffer_on
);

  // ********************************************************
  // register storage
  // ********************************************************
  logic [7:0]  ctrl_a_r, ctrl_a_nxt;          // enable, waveform, flag, ie, blank
  logic [9:0]  ctrl_b_r, ctrl_b_nxt;          // clock, bias, duty, mask, ext, pwr
  logic [6:0]  frame_rate_r, frame_rate_nxt;  // prescale [6:4], divide [2:0]
  logic [2:0]  drive_time_select_r, drive_time_nxt;
  logic [SEG_COUNT-1:0] mem_r [4];           // display memory per common
  logic [SEG_COUNT-1:0] mem_nxt [4];
  logic [SEG_COUNT-1:0] latch_r [4];         // frame copy of memory
  logic [SEG_COUNT-1:0] latch_nxt [4];
  logic        lowpwr_r, lowpwr_nxt;          // waveform used by this frame
  logic        blank_act_r, blank_act_nxt;    // blanking in force

  // axi handshake state
  logic        aw_got_r, aw_got_nxt;
  logic        w_got_r, w_got_nxt;
  logic [7:0]  aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  rresp_r, rresp_nxt;

  // timing chain
  logic        src_d_r, src_d_nxt;            // previous level of chosen clock
  logic [`PRESCALE_BITS-1:0] ripple_r, ripple_nxt;
  logic [2:0]  div_r, div_nxt;
  logic [1:0]  com_idx_r, com_idx_nxt;
  logic        phase_r, phase_nxt;            // polarity of current half
  logic        pair_r, pair_nxt;              // second frame of low power pair
  logic [7:0]  drive_cnt_r, drive_cnt_nxt;
  lcd_frame_pkg::seq_state_e state_r, state_nxt;

  // ********************************************************
  // helpers
  // ********************************************************
  // prescale code ascends
  function automatic logic [3:0] tap_of(input logic [2:0] code);
    logic [3:0] t;
    t = 4'h0;
    case (code)
      3'h0:    t = 4'h3;
      3'h1:    t = 4'h5;
      3'h2:    t = 4'h6;
      3'h3:    t = 4'h7;
      3'h4:    t = 4'h8;
      3'h5:    t = 4'h9;
      3'h6:    t = 4'hA;
      default: t = 4'hB;
    endcase
    return t;
  endfunction

  // number of commons used minus one
  function automatic logic [1:0] last_com(input logic [1:0] mux);
    return mux;
  endfunction

  // ********************************************************
  // derived controls
  // ********************************************************
  logic        running;      // module active and allowed to run
  logic        clk_src;      // selected lcd clock level
  logic        src_rise;     // one-cycle edge of lcd clock
  logic        ps_tick;      // prescaled clock enable
  logic        frame_tick;   // divided timing enable
  logic        frame_start;  // first common of a new frame
  logic        latch_now;    // data latched this frame start
  logic        sleep_ok;
  logic [7:0]  drive_len;

  always_comb
  begin
    // sleep: sync clock allowed in idle/save, async also in adc noise
    sleep_ok = ~sleep_adc_noise | ctrl_b_r[`CB_CLKSEL];
    // module stays off under power reduction
    running  = ctrl_a_r[`CA_ENABLE] & ~ctrl_b_r[`CB_PWRRED] & sleep_ok;
    // source mux of io clock enable or oscillator pin
    clk_src  = ctrl_b_r[`CB_CLKSEL] ? timer_oscillator_pin : 1'b1;
  end

  assign ext_clock_buffer_en = ctrl_b_r[`CB_EXTCLK] & ctrl_b_r[`CB_CLKSEL];

  // lcd clock edges; io clock counts every cycle
  assign src_rise = ctrl_b_r[`CB_CLKSEL] ? (clk_src & ~src_d_r) : 1'b1;
  // prescaler tap rising
  assign ps_tick  = src_rise && (ripple_nxt[tap_of(frame_rate_r[6:4])] &
                                 ~ripple_r[tap_of(frame_rate_r[6:4])]);
  assign frame_tick  = ps_tick && (div_r == frame_rate_r[2:0]);
  assign frame_start = frame_tick && (com_idx_r == last_com(ctrl_b_r[5:4])) && phase_r;
  assign latch_now   = frame_start && (~lowpwr_r || pair_r);

  // drive time in io cycles, capped at a quarter prescaled period when multiplexed
  always_comb
  begin
    drive_len = 8'({drive_time_select_r, 1'b0} + 4'h1) * 8'(`DRIVE_UNIT_CYC / 2);
    if (ctrl_b_r[5:4] != 2'b00 && tap_of(frame_rate_r[6:4]) <= 4'h8
        && drive_len > 8'(1 << tap_of(frame_rate_r[6:4]) >> 1))
    begin
      drive_len = 8'(1 << tap_of(frame_rate_r[6:4]) >> 1);
    end
  end

  // ********************************************************
  // axi lite slave
  // ********************************************************
  logic wr_fire;
  logic [7:0] rd_addr;

  assign s_axi_awready = ~aw_got_r & ~bvalid_r;
  assign s_axi_wready  = ~w_got_r & ~bvalid_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign rd_addr       = s_axi_araddr;

  always_comb
  begin
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt  = w_data_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt  = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    wr_fire    = 1'b0;
    // capture address and data in any order
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_got_nxt  = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_got_nxt  = 1'b1;
      w_data_nxt = s_axi_wdata;
    end
    // both present: commit and answer
    if (aw_got_r && w_got_r)
    begin
      wr_fire    = 1'b1;
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = (aw_addr_r <= `REG_STATUS || (aw_addr_r >= `REG_MEM_BASE && aw_addr_r <= `REG_MEM_LAST))
                 ? 2'b00 : 2'b10;
    end
    else if (bvalid_r && s_axi_bready)
    begin
      bvalid_nxt = 1'b0;
    end
    // reads answer one cycle after acceptance
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = 2'b00;
      case (rd_addr)
        `REG_CTRL_A:     rdata_nxt = 32'(ctrl_a_r & 8'hD9);
        `REG_CTRL_B:     rdata_nxt = 32'(ctrl_b_r);
        `REG_FRAME_RATE: rdata_nxt = 32'(frame_rate_r);
        `REG_CONTRAST:   rdata_nxt = 32'(drive_time_select_r);
        `REG_STATUS:     rdata_nxt = 32'({blank_act_r, mid_buffer_on, com_idx_r});
        8'h20:           rdata_nxt = 32'(mem_r[0]);
        8'h24:           rdata_nxt = 32'(mem_r[1]);
        8'h28:           rdata_nxt = 32'(mem_r[2]);
        8'h2C:           rdata_nxt = 32'(mem_r[3]);
        default:
        begin
          rdata_nxt = `RST_ZERO;
          rresp_nxt = 2'b10;
        end
      endcase
    end
    else if (rvalid_r && s_axi_rready)
    begin
      rvalid_nxt = 1'b0;
    end
  end

  // ********************************************************
  // register writes and frame flag
  // ********************************************************
  always_comb
  begin
    ctrl_a_nxt     = ctrl_a_r;
    ctrl_b_nxt     = ctrl_b_r;
    frame_rate_nxt = frame_rate_r;
    drive_time_nxt = drive_time_select_r;
    for (int i = 0; i < 4; i++)
    begin
      mem_nxt[i] = mem_r[i];
    end
    if (wr_fire)
    begin
      case (aw_addr_r)
        `REG_CTRL_A:
        begin
          ctrl_a_nxt = w_data_r[7:0] & 8'hC9;
          ctrl_a_nxt[`CA_FLAG] = ctrl_a_r[`CA_FLAG] & ~w_data_r[`CA_FLAG];
        end
        `REG_CTRL_B:     ctrl_b_nxt = w_data_r[9:0];
        `REG_FRAME_RATE: frame_rate_nxt = w_data_r[6:0];
        `REG_CONTRAST:   drive_time_nxt = w_data_r[2:0];
        8'h20:           mem_nxt[0] = SEG_COUNT'(w_data_r);
        8'h24:           mem_nxt[1] = SEG_COUNT'(w_data_r);
        8'h28:           mem_nxt[2] = SEG_COUNT'(w_data_r);
        8'h2C:           mem_nxt[3] = SEG_COUNT'(w_data_r);
        default:         ctrl_a_nxt = ctrl_a_r;
      endcase
    end
    // interrupt vector acknowledge clears the flag
    if (frame_irq_ack)
    begin
      ctrl_a_nxt[`CA_FLAG] = 1'b0;
    end
    if (running && latch_now)
    begin
      ctrl_a_nxt[`CA_FLAG] = 1'b1;
    end
  end

  assign frame_irq = ctrl_a_r[`CA_FLAG] & ctrl_a_r[`CA_IE];

  // ********************************************************
  // timing chain and sequencer
  // ********************************************************
  always_comb
  begin
    src_d_nxt     = clk_src;
    ripple_nxt    = ripple_r;
    div_nxt       = div_r;
    com_idx_nxt   = com_idx_r;
    phase_nxt     = phase_r;
    pair_nxt      = pair_r;
    state_nxt     = state_r;
    lowpwr_nxt    = lowpwr_r;
    blank_act_nxt = blank_act_r;
    drive_cnt_nxt = (drive_cnt_r != 8'h00) ? drive_cnt_r - 8'h01 : 8'h00;
    for (int i = 0; i < 4; i++)
    begin
      latch_nxt[i] = latch_r[i];
    end
    if (running && src_rise)
    begin
      ripple_nxt = ripple_r + 12'h001;
    end
    if (ps_tick)
    begin
      div_nxt = (div_r == frame_rate_r[2:0]) ? 3'h0 : div_r + 3'h1;
    end
    case (state_r)
      lcd_frame_pkg::ST_OFF:
      begin
        com_idx_nxt = 2'h0;
        phase_nxt   = 1'b0;
        if (running && supply_ready)
        begin
          state_nxt = lcd_frame_pkg::ST_RUN;
          for (int i = 0; i < 4; i++)
          begin
            latch_nxt[i] = mem_r[i];
          end
          lowpwr_nxt = ctrl_a_r[`CA_LOWPWR];
          blank_act_nxt = ctrl_a_r[`CA_BLANK];
        end
      end
      lcd_frame_pkg::ST_RUN, lcd_frame_pkg::ST_BLANK:
      begin
        if (frame_tick)
        begin
          // start drive pulse at each transition
          drive_cnt_nxt = drive_len;
          phase_nxt = ~phase_r;
          if (phase_r)
          begin
            com_idx_nxt = (com_idx_r == last_com(ctrl_b_r[5:4])) ? 2'h0 : com_idx_r + 2'h1;
          end
        end
        if (frame_start)
        begin
          pair_nxt   = lowpwr_r ? ~pair_r : 1'b0;
          lowpwr_nxt = (lowpwr_r && !pair_r) ? lowpwr_r : ctrl_a_r[`CA_LOWPWR];
        end
        if (latch_now)
        begin
          for (int i = 0; i < 4; i++)
          begin
            latch_nxt[i] = mem_r[i];
          end
          blank_act_nxt = ctrl_a_r[`CA_BLANK];
          state_nxt = ctrl_a_r[`CA_BLANK] ? lcd_frame_pkg::ST_BLANK : lcd_frame_pkg::ST_RUN;
        end
        if (!running || !supply_ready)
        begin
          state_nxt = lcd_frame_pkg::ST_OFF;
          blank_act_nxt = 1'b0;
        end
      end
      default: state_nxt = lcd_frame_pkg::ST_OFF;
    endcase
  end

  // ********************************************************
  // pin drive
  // ********************************************************
  logic [SEG_COUNT-1:0] seg_used;
  logic [3:0]           com_used;
  logic [SEG_COUNT-1:0] seg_lvl_nxt;
  logic [3:0]           com_lvl_nxt;
  logic                 live;

  always_comb
  begin
    seg_used = '0;
    for (int s = 0; s < SEG_COUNT; s++)
    begin
      seg_used[s] = (s < 24 + int'(ctrl_b_r[3:0])) || (ctrl_b_r[3:0] == 4'hF);
    end
    for (int c = 0; c < 4; c++)
    begin
      com_used[c] = (c <= int'(ctrl_b_r[5:4]));
    end
    live = (state_r != lcd_frame_pkg::ST_OFF);
    // on segments opposite phase, off in phase
    com_lvl_nxt = '0;
    com_lvl_nxt[com_idx_r] = phase_r;
    for (int s = 0; s < SEG_COUNT; s++)
    begin
      seg_lvl_nxt[s] = latch_r[com_idx_r][s] ? ~phase_r : phase_r;
    end
    // all pins to ground while blanked
    if (blank_act_r || !live)
    begin
      com_lvl_nxt = '0;
      seg_lvl_nxt = '0;
    end
  end

  // drive pulse turns on midpoint buffers, whatever the bias bit, but not while blanked; capped pulse
  assign mid_buffer_on = live && (drive_cnt_r != 8'h00) && !blank_act_r;
  assign seg_lcd_owned = live ? seg_used : '0;
  assign com_lcd_owned = live ? com_used : '0;
  // tristate after drive time except when blanking grounds pins or in static duty
  assign seg_oe = (live && (mid_buffer_on || blank_act_r || ctrl_b_r[5:4] == 2'b00)) ? seg_used : '0;
  assign com_oe = (live && (mid_buffer_on || blank_act_r || ctrl_b_r[5:4] == 2'b00)) ? com_used : '0;

  // ********************************************************
  // registers
  // ********************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_a_r <= 8'h00;
      ctrl_b_r <= 10'h000;
      frame_rate_r <= 7'h00;
      drive_time_select_r <= 3'h0;
      for (int i = 0; i < 4; i++)
      begin
        mem_r[i]   <= '0;
        latch_r[i] <= '0;
      end
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= `RST_ZERO;
      bvalid_r <= 1'b0;
      bresp_r  <= 2'b00;
      rvalid_r <= 1'b0;
      rdata_r  <= `RST_ZERO;
      rresp_r  <= 2'b00;
      src_d_r  <= 1'b0;
      ripple_r <= 12'h000;
      div_r    <= 3'h0;
      com_idx_r <= 2'h0;
      phase_r  <= 1'b0;
      pair_r   <= 1'b0;
      drive_cnt_r <= 8'h00;
      state_r  <= lcd_frame_pkg::ST_OFF;
      lowpwr_r <= 1'b0;
      blank_act_r <= 1'b0;
      seg_level <= '0;
      com_level <= '0;
    end
    else
    begin
      ctrl_a_r <= ctrl_a_nxt;
      ctrl_b_r <= ctrl_b_nxt;
      frame_rate_r <= frame_rate_nxt;
      drive_time_select_r <= drive_time_nxt;
      for (int i = 0; i < 4; i++)
      begin
        mem_r[i]   <= mem_nxt[i];
        latch_r[i] <= latch_nxt[i];
      end
      aw_got_r <= aw_got_nxt;
      w_got_r  <= w_got_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r <= w_data_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r  <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r  <= rdata_nxt;
      rresp_r  <= rresp_nxt;
      src_d_r  <= src_d_nxt;
      ripple_r <= ripple_nxt;
      div_r    <= div_nxt;
      com_idx_r <= com_idx_nxt;
      phase_r  <= phase_nxt;
      pair_r   <= pair_nxt;
      drive_cnt_r <= drive_cnt_nxt;
      state_r  <= state_nxt;
      lowpwr_r <= lowpwr_nxt;
      blank_act_r <= blank_act_nxt;
      seg_level <= seg_lvl_nxt;
      com_level <= com_lvl_nxt;
    end
  end

endmodule // segment_lcd_frame_controller
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lcd_frame_defines.svh"
module testbench;
  // ****************************************
  // signals
  // ****************************************
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, timer_oscillator_pin, supply_ready, sleep_idle_or_save;
  logic        sleep_adc_noise, frame_irq_ack, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, ext_clock_buffer_en, frame_irq, mid_buffer_on;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb, com_level, com_oe, com_lcd_owned;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [39:0] seg_level, seg_oe, seg_lcd_owned;
  logic [15:0] on0, on1, pos0, neg0;
  int          n_mismatch = 0;
  int          comparisons = 0;
  // rows: write, address, data, readback, response
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} row_s;
  row_s rows [6] = '{
    '{1'h0, `REG_CTRL_A, 32'h0000_0000, 32'h0000_0000, 2'h0},
    '{1'h1, `REG_FRAME_RATE, 32'h0000_0073, 32'h0000_0073, 2'h0},
    '{1'h1, `REG_CONTRAST, 32'h0000_0007, 32'h0000_0007, 2'h0},
    '{1'h1, `REG_MEM_BASE, 32'hA5A5_5A5A, 32'hA5A5_5A5A, 2'h0},
    '{1'h1, `REG_MEM_LAST, 32'h0000_FFFF, 32'h0000_FFFF, 2'h0},
    '{1'h1, 8'h40, 32'h0000_0001, 32'h0000_0000, 2'h2}};

  segment_lcd_frame_controller #(.SEG_COUNT(40)) i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .timer_oscillator_pin, .supply_ready, .sleep_idle_or_save, .sleep_adc_noise, .frame_irq_ack,
    .ext_clock_buffer_en, .frame_irq, .seg_level, .seg_oe, .seg_lcd_owned, .com_level, .com_oe,
    .com_lcd_owned, .mid_buffer_on);
  lcd_panel_model i_panel (.aclk, .seg_level(seg_level[1:0]), .seg_oe(seg_oe[1:0]),
    .com_level(com_level[0]), .com_oe(com_oe[0]), .on0, .on1, .pos0, .neg0);

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] s);
    comparisons++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    chk("bus wait", 0, n >= 200);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk("bus wait", 0, n >= 200);
  endtask
  // acknowledge the flag, then wait for the next frame start
  task automatic wait_frame();
    int n = 0;
    @(posedge aclk);
    frame_irq_ack <= 1'b1;
    @(posedge aclk);
    frame_irq_ack <= 1'b0;
    @(posedge aclk);
    chk("irq after ack", 0, frame_irq);
    while (frame_irq !== 1'b1 && n < 5000)
    begin
      @(posedge aclk);
      n++;
    end
    chk("frame wait", 0, n >= 5000);
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************
  // clock, watchdog and sequence
  // ****************************************
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial
  begin
    #500_000;
    n_mismatch++;
    close_out();
  end
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {timer_oscillator_pin, supply_ready, sleep_idle_or_save, sleep_adc_noise, frame_irq_ack} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    // ordinary register cases
    foreach (rows[i])
    begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d, rs);
      if (rows[i].w)
        chk("bresp", rows[i].r, rs);
      rd(rows[i].a, rdat, rs);
      chk("rdata", rows[i].e, rdat);
      chk("rresp", rows[i].r, rs);
    end
    // fastest frame rate keeps the run short
    wr(`REG_FRAME_RATE, 32'h0000_0000, rs);
    wr(`REG_MEM_BASE, 32'h0000_0001, rs);
    wr(`REG_CTRL_B, 32'h0000_0000, rs);
    wr(`REG_CTRL_A, 32'h0000_0088, rs);
    repeat (50) @(posedge aclk);
    chk("seg_oe before supply", 0, seg_oe);
    supply_ready <= 1'b1;
    sleep_idle_or_save <= 1'b1;
    wait_frame();
    chk("frame_irq", 1, frame_irq);
    rd(`REG_CTRL_A, rdat, rs);
    chk("frame flag", 1, rdat[`CA_FLAG]);
    repeat (400) @(posedge aclk);
    chk("seg0 on", 1, on0 != 16'h0000);
    chk("seg1 off", 0, on1 != 16'h0000);
    chk("both signs", 1, pos0 != 16'h0000 && neg0 != 16'h0000);
    chk("seg owned", 40'h00_00FF_FFFF, seg_lcd_owned);
    chk("com owned", 4'h1, com_lcd_owned);
    // blanking after a whole frame, memory kept
    wr(`REG_CTRL_A, 32'h0000_0089, rs);
    wait_frame();
    wait_frame();
    chk("seg_level blank", 0, seg_level);
    chk("com_level blank", 0, com_level);
    rd(`REG_MEM_BASE, rdat, rs);
    chk("memory kept", 32'h0000_0001, rdat);
    wr(`REG_CTRL_A, 32'h0000_0000, rs);
    repeat (2) @(posedge aclk);
    chk("owned after disable", 0, seg_lcd_owned);
    // power reduction keeps the module idle
    wr(`REG_CTRL_B, 32'h0000_0200, rs);
    wr(`REG_CTRL_A, 32'h0000_0080, rs);
    repeat (100) @(posedge aclk);
    chk("seg_oe reduced", 0, seg_oe);
    wr(`REG_CTRL_B, 32'h0000_0100, rs);
    chk("ext buffer sync", 0, ext_clock_buffer_en);
    wr(`REG_CTRL_B, 32'h0000_0180, rs);
    chk("ext buffer async", 1, ext_clock_buffer_en);
    close_out();
  end
endmodule // testbench
`default_nettype wire
